/* src/adc_cal_consts.svh */
// Purpose: constants of the converter calibration control register
// Assumes: included by its bare name
// Notes: every field position, reset value and count lives here
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

// register select address of the calibration control register
`define CAL_SFR_ADDR 8'hf5
// power-on contents of the whole register
`define CAL_RESET_VALUE 8'h00
// field positions
`define CAL_BUSY_BIT 7
`define CAL_GAIN_DIS_BIT 6
`define CAL_AVG_HI_BIT 5
`define CAL_AVG_LO_BIT 4
`define CAL_RSVD_BIT 3
`define CAL_ENABLE_BIT 2
`define CAL_TYPE_BIT 1
`define CAL_START_BIT 0
// average select codes
`define CAL_AVG_CODE_15 2'h0
`define CAL_AVG_CODE_1 2'h1
`define CAL_AVG_CODE_31 2'h2
`define CAL_AVG_CODE_63 2'h3
// readings per calibration for each code
`define CAL_AVG_COUNT_15 6'h0f
`define CAL_AVG_COUNT_1 6'h01
`define CAL_AVG_COUNT_31 6'h1f
`define CAL_AVG_COUNT_63 6'h3f
// widths of the reading counter, the result and the sum
`define CAL_CNT_W 6
`define CAL_RESULT_W 12
`define CAL_SUM_W 18
`define CAL_SUM_PAD 6'h00

`endif

/* src/adc_cal_pkg.sv */
// Purpose: types shared by the calibration control logic
// Assumes: constants come from adc_cal_consts.svh
// Notes: none
package adc_cal_pkg;
  // calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_SAMPLE = 2'b01,
    CAL_WAIT = 2'b10,
    CAL_FINISH = 2'b11
  } cal_state_t;

  // one register byte
  typedef logic [7:0] sfr_byte_t;
  // reading counter value
  typedef logic [5:0] cal_count_t;
  // converter result and running sum
  typedef logic [11:0] cal_result_t;
  typedef logic [17:0] cal_sum_t;
endpackage

/* src/cal_average_counter.sv */
// Purpose: counts converter readings still owed by a calibration
// Assumes: load and step never coincide
// Notes: lastReading marks the final reading of the average
`timescale 1ns/1ps
module cal_average_counter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire adc_cal_pkg::cal_count_t loadValue,
  input wire logic step,
  output logic lastReading
);
  import adc_cal_pkg::*;

  cal_count_t remaining;
  cal_count_t next_remaining;

  // reload at launch, count down one per finished reading
  always_comb begin
    next_remaining = remaining;
    if (load) begin
      next_remaining = loadValue;
    end else if (step && remaining != 6'h00) begin
      next_remaining = remaining - 6'h01;
    end
  end

  // register the count
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      remaining <= 6'h00;
    end else begin
      remaining <= next_remaining;
    end
  end

  assign lastReading = (remaining == 6'h01);

  a_count_down: assert property (@(posedge mclk) disable iff (sys_rst)
    (step && !load && remaining > 6'h01) |=> remaining == $past(remaining) - 6'h01)
    else $error("reading counter did not step down by one");
endmodule // cal_average_counter

/* src/adc_calibration_control.sv */
// Purpose: calibration control and status register of the 12-bit converter
// Assumes: convBusy, convDone and convResult come from converter logic on mclk
// Notes: sfrRdData shows the register one cycle after any change
//
// How it works
// - busy bit 7 reads high while a conversion or calibration runs; writes ignored.
// - busy drops by itself once the running cycle finishes.
// - gain calibration runs only while disable bit 6 is zero.
// - bits 5:4 pick 15, 1, 31 or 63 averaged readings.
// - bit 1 zero selects offset calibration, one selects gain calibration.
// - setting bit 0 starts calibration; hardware clears it at completion.
// - the register holds all zeros after reset.
`timescale 1ns/1ps
`include "adc_cal_consts.svh"
module adc_calibration_control (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire adc_cal_pkg::sfr_byte_t sfrAddr,
  input wire logic sfrWrite,
  input wire adc_cal_pkg::sfr_byte_t sfrWrData,
  output adc_cal_pkg::sfr_byte_t sfrRdData,
  input wire logic convBusy,
  input wire logic convDone,
  input wire adc_cal_pkg::cal_result_t convResult,
  output logic calStartConv,
  output logic calMode,
  output logic calDone,
  output adc_cal_pkg::cal_sum_t calSum,
  output adc_cal_pkg::cal_count_t calReadings
);
  import adc_cal_pkg::*;

  cal_state_t state;
  cal_state_t next_state;
  logic [6:1] cfgBits;
  logic [6:1] next_cfgBits;
  logic startBit;
  logic next_startBit;
  logic next_calMode;
  logic next_calDone;
  logic suppressed;
  logic next_suppressed;
  cal_sum_t next_calSum;
  cal_count_t next_calReadings;
  sfr_byte_t next_sfrRdData;
  sfr_byte_t cfgEff;
  cal_count_t avgCount;
  logic wrSel;
  logic launch;
  logic launchSuppressed;
  logic busy;
  logic readingDone;
  logic lastReading;

  // write decode and the configuration seen by a launch this cycle
  assign wrSel = sfrWrite && (sfrAddr == `CAL_SFR_ADDR);
  assign cfgEff = wrSel ? sfrWrData : {1'b0, cfgBits, startBit};
  // a start is taken only when idle and the converter is free
  assign launch = (state == CAL_IDLE) && !convBusy && (startBit || cfgEff[`CAL_START_BIT]);
  // gain type with gain disabled runs no readings
  assign launchSuppressed = launch && cfgEff[`CAL_TYPE_BIT] && cfgEff[`CAL_GAIN_DIS_BIT];
  assign readingDone = (state == CAL_WAIT) && convDone;
  // busy covers normal conversions, a pending start and every non-idle state
  // a pending start counts as busy, so the launch cycle leaves no gap in busy
  assign busy = (state != CAL_IDLE) || convBusy || startBit;
  assign calStartConv = (state == CAL_SAMPLE);

  // readings per average from the select field
  always_comb begin
    avgCount = `CAL_AVG_COUNT_15;
    unique case (cfgEff[`CAL_AVG_HI_BIT:`CAL_AVG_LO_BIT])
      `CAL_AVG_CODE_15: avgCount = `CAL_AVG_COUNT_15;
      `CAL_AVG_CODE_1: avgCount = `CAL_AVG_COUNT_1;
      `CAL_AVG_CODE_31: avgCount = `CAL_AVG_COUNT_31;
      `CAL_AVG_CODE_63: avgCount = `CAL_AVG_COUNT_63;
    endcase
  end

  // register contents: config bits stored as written, start self-clears
  always_comb begin
    next_cfgBits = cfgBits;
    next_startBit = startBit;
    if (wrSel) begin
      next_cfgBits = sfrWrData[6:1];
    end
    if (state == CAL_FINISH) begin
      next_startBit = 1'b0;
    end else if (wrSel && sfrWrData[`CAL_START_BIT]) begin
      next_startBit = 1'b1;
    end
    // busy bit is never stored, so writes to it vanish
    next_sfrRdData = {busy, cfgBits, startBit};
  end

  // calibration sequencer
  always_comb begin
    next_state = state;
    next_calMode = calMode;
    next_calDone = 1'b0;
    next_suppressed = suppressed;
    next_calSum = calSum;
    next_calReadings = calReadings;
    unique case (state)
      CAL_IDLE: begin
        if (launch) begin
          next_calMode = cfgEff[`CAL_TYPE_BIT];
          next_suppressed = launchSuppressed;
          next_calSum = '0;
          next_calReadings = avgCount;
          next_state = launchSuppressed ? CAL_FINISH : CAL_SAMPLE;
        end
      end
      CAL_SAMPLE: begin
        next_state = CAL_WAIT;
      end
      CAL_WAIT: begin
        if (convDone) begin
          next_calSum = calSum + {`CAL_SUM_PAD, convResult};
          if (lastReading) begin
            next_calDone = 1'b1;
            next_state = CAL_FINISH;
          end else begin
            next_state = CAL_SAMPLE;
          end
        end
      end
      CAL_FINISH: begin
        next_state = CAL_IDLE;
      end
    endcase
  end

  // register all state
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= CAL_IDLE;
      cfgBits <= 6'h00;
      startBit <= 1'b0;
      calMode <= 1'b0;
      calDone <= 1'b0;
      suppressed <= 1'b0;
      calSum <= '0;
      calReadings <= 6'h00;
      sfrRdData <= `CAL_RESET_VALUE;
    end else begin
      state <= next_state;
      cfgBits <= next_cfgBits;
      startBit <= next_startBit;
      calMode <= next_calMode;
      calDone <= next_calDone;
      suppressed <= next_suppressed;
      calSum <= next_calSum;
      calReadings <= next_calReadings;
      sfrRdData <= next_sfrRdData;
    end
  end

  // readings still owed by the running calibration
  cal_average_counter readingCounter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(launch),
    .loadValue(avgCount),
    .step(readingDone),
    .lastReading(lastReading)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_busy_running: assert property ((state != CAL_IDLE) |=> sfrRdData[`CAL_BUSY_BIT])
    else $error("busy not shown during calibration");
  a_busy_clears: assert property (
    (state == CAL_FINISH ##1 !convBusy) |=> !sfrRdData[`CAL_BUSY_BIT])
    else $error("busy stayed high after the cycle ended");
  a_gain_suppress: assert property (
    launchSuppressed |=> (state == CAL_FINISH && !calStartConv) ##1 (state == CAL_IDLE && !calDone))
    else $error("disabled gain calibration still ran");
  a_avg_count: assert property ((launch && !launchSuppressed) |=>
    (calReadings == $past(avgCount) && state == CAL_SAMPLE))
    else $error("wrong number of averages loaded");
  a_more_readings: assert property ((readingDone && !lastReading) |=> calStartConv)
    else $error("next reading not requested");
  a_type_latch: assert property (launch |=> calMode == $past(cfgEff[`CAL_TYPE_BIT]))
    else $error("calibration type not taken from bit 1");
  a_start_clear: assert property ((state == CAL_FINISH) |=> (!startBit && state == CAL_IDLE))
    else $error("start bit not cleared at completion");
  a_start_launch: assert property ((state == CAL_IDLE && startBit && !convBusy) |=>
    (state != CAL_IDLE && sfrRdData[`CAL_BUSY_BIT]) ##1 sfrRdData[`CAL_BUSY_BIT])
    else $error("pending start not launched");
  a_reset_value: assert property (@(posedge mclk) disable iff (1'b0)
    $fell(sys_rst) |-> (sfrRdData == `CAL_RESET_VALUE && cfgBits == 6'h00 && !startBit))
    else $error("register not zero after reset");
  a_done_finish: assert property (calDone |-> (state == CAL_FINISH && !suppressed))
    else $error("done pulse outside a completed calibration");

  // start bit holding, idle busy level, offset runs and latched run settings
  a_start_set: assert property (
    (wrSel && sfrWrData[`CAL_START_BIT] && state != CAL_FINISH) |=> startBit)
    else $error("written start bit not held");
  a_idle_clear: assert property (
    (state == CAL_IDLE && !convBusy && !startBit) |=> !sfrRdData[`CAL_BUSY_BIT])
    else $error("busy shown while nothing runs");
  a_offset_runs: assert property (
    (launch && !cfgEff[`CAL_TYPE_BIT]) |=> calStartConv)
    else $error("offset calibration did not request a reading");
  a_sum_clear: assert property (
    launch |=> calSum == 18'h00000)
    else $error("sum not cleared at launch");
  a_wait_hold: assert property (
    (state == CAL_WAIT && !convDone) |=> (state == CAL_WAIT && !calStartConv))
    else $error("reading wait left without converter answer");
  a_mode_hold: assert property (
    (state != CAL_IDLE) |=> $stable(calMode))
    else $error("calibration type changed during a run");

  c_offset_cal: cover property (launch && !cfgEff[`CAL_TYPE_BIT] ##[1:300] calDone);
  c_gain_cal: cover property (launch && cfgEff[`CAL_TYPE_BIT] ##[1:300] calDone);
  c_suppressed: cover property (launchSuppressed);
  c_pending_start: cover property (startBit && convBusy && state == CAL_IDLE ##1 launch);
endmodule // adc_calibration_control

/* testbench/adc_calibration_control_tb.sv */
// Purpose: self-checking bench of the calibration control register
// Assumes: design assertions run alongside; bench drives at the falling edge
// Notes: bench plays the converter by answering calStartConv with convDone
`timescale 1ns/1ps
module adc_calibration_control_tb;
  import adc_cal_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  sfr_byte_t sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  sfr_byte_t sfrWrData = 8'h00;
  logic convBusy = 1'b0;
  logic convDone = 1'b0;
  cal_result_t convResult = 12'h000;
  sfr_byte_t sfrRdData;
  logic calStartConv;
  logic calMode;
  logic calDone;
  cal_sum_t calSum;
  cal_count_t calReadings;
  int fail_count = 0;
  int n_tests = 0;
  int cnt[4] = '{15, 1, 31, 63};

  // 250 MHz core clock
  always #2 mclk = ~mclk;

  adc_calibration_control dut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite),
    .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData),
    .convBusy(convBusy),
    .convDone(convDone),
    .convResult(convResult),
    .calStartConv(calStartConv),
    .calMode(calMode),
    .calDone(calDone),
    .calSum(calSum),
    .calReadings(calReadings)
  );

  // compare one value, log any mismatch
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one register write, entered and left at a falling edge
  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge mclk);
    sfrWrite = 1'b0;
  endtask

  // answer n reading requests, then check results and readback
  task automatic serve(input sfr_byte_t d, input int n, input logic mode);
    int k;
    for (int i = 1; i <= n; i++) begin
      k = 0;
      while (calStartConv !== 1'b1 && k < 8) begin
        @(negedge mclk);
        k++;
      end
      chk("calStartConv", calStartConv, 1'b1);
      @(negedge mclk);
      chk("busy", sfrRdData[7], 1'b1);
      convDone = 1'b1;
      convResult = i[11:0];
      @(negedge mclk);
      convDone = 1'b0;
    end
    chk("calDone", calDone, 1'b1);
    chk("calSum", calSum, 18'(n * (n + 1) / 2));
    chk("calReadings", calReadings, 18'(n));
    chk("calMode", calMode, mode);
    repeat (3) @(negedge mclk);
    chk("readback", sfrRdData, {10'h000, 1'b0, d[6:1], 1'b0});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #20000;
    fail_count++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end

  // main sequence
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst = 1'b0;
    chk("reset", sfrRdData, 8'h00);
    chk("reset sum", calSum, 18'h00000);
    wr(8'hf4, 8'h7f);
    repeat (3) @(negedge mclk);
    chk("other addr", sfrRdData, 8'h00);
    wr(8'hf5, 8'h80);
    repeat (3) @(negedge mclk);
    chk("busy write", sfrRdData, 8'h00);
    $display("test reset and read-only done");
    for (int c = 0; c < 4; c++) begin
      wr(8'hf5, {2'b00, 2'(c), 4'h5});
      serve({2'b00, 2'(c), 4'h5}, cnt[c], 1'b0);
    end
    $display("test average codes done");
    wr(8'hf5, 8'h17);
    serve(8'h17, 1, 1'b1);
    $display("test gain calibration done");
    wr(8'hf5, 8'h47);
    repeat (6) begin
      chk("no request", calStartConv, 1'b0);
      chk("no done", calDone, 1'b0);
      @(negedge mclk);
    end
    chk("suppressed", sfrRdData, 8'h46);
    $display("test gain disabled done");
    convBusy = 1'b1;
    @(negedge mclk);
    wr(8'hf5, 8'h15);
    repeat (3) begin
      chk("pending", calStartConv, 1'b0);
      @(negedge mclk);
    end
    chk("pending read", sfrRdData, 8'h95);
    convBusy = 1'b0;
    @(negedge mclk);
    chk("no gap", sfrRdData[7], 1'b1);
    serve(8'h15, 1, 1'b0);
    $display("test pending start done");
    close_out();
  end
endmodule // adc_calibration_control_tb
